// ==== inc/flai_pkg.sv ====
// Shared constants and types for the fault log array interface.
package flai_pkg;

  // Local logging array geometry.
  localparam int        ADDR_W    = 10;
  localparam int        DEPTH     = 1024;
  localparam logic [9:0] ADDR_LAST = 10'h3FF;
  localparam logic [9:0] ADDR_ZERO = 10'h000;
  localparam logic [9:0] ADDR_STEP = 10'h001;

  // Timing, in nanoseconds, and the derived cycle counts at 20 MHz.
  localparam int CLK_PERIOD_NS  = 50;
  localparam int SCAN_SETTLE_NS = 2000;
  localparam int COPY_SETTLE_NS = 100000;
  localparam int COPY_MAX_NS    = 250000000;
  localparam int DELAY_W        = 11;
  // The 2 us wait is a least time, so it rounds up.
  localparam logic [10:0] SCAN_SETTLE =
    11'((SCAN_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  // The 100 us wait is a longest time, so it rounds down.
  localparam logic [10:0] COPY_SETTLE = 11'(COPY_SETTLE_NS / CLK_PERIOD_NS);
  localparam logic [10:0] DELAY_ZERO  = 11'h000;
  localparam logic [10:0] DELAY_STEP  = 11'h001;

  // Word bit positions; word bit 0 is the most significant (index 15).
  localparam int POS_B0    = 15;
  localparam int POS_B1    = 14;
  localparam int POS_B2    = 13;
  localparam int POS_B3    = 12;
  localparam int POS_B4    = 11;
  localparam int POS_B5    = 10;
  localparam int POS_B7    = 8;
  localparam int ADDR_MSB  = 9;
  localparam int ADDR_LSB  = 0;

  // Command kinds presented with the strobe.
  typedef enum logic [1:0] {
    CMD_STATUS  = 2'h0,
    CMD_CONTROL = 2'h1,
    CMD_WRITE   = 2'h2,
    CMD_READ    = 2'h3
  } flai_cmd_kind_t;

  // Sequencer states, one-hot.
  typedef enum logic [5:0] {
    ST_IDLE     = 6'h01,
    ST_COPY_IN  = 6'h02,
    ST_COPY_OUT = 6'h04,
    ST_FILL     = 6'h08,
    ST_SCAN     = 6'h10,
    ST_HALT     = 6'h20
  } flai_state_t;

  // One command from the I/O processor bus.
  typedef struct packed {
    logic           valid;
    flai_cmd_kind_t kind;
    logic [15:0]    word;
  } flai_cmd_t;

  // Signals arriving from the memory control card.
  typedef struct packed {
    logic       refresh;
    logic       rd_bit;
    logic [9:0] addr;
  } flai_mem_in_t;

  // Signals driven to the memory control cards.
  typedef struct packed {
    logic we;
    logic wr_bit;
    logic upper_half;
    logic corr_disable;
  } flai_mem_out_t;

endpackage

// ==== verilog/flai_bit_array.sv ====
// One-bit-wide local logging array with a write port and a read port.
`timescale 1ns/100ps
module flai_bit_array (
  input  wire logic       sys_clk,
  input  wire logic       we,
  input  wire logic [9:0] waddr,
  input  wire logic       wdata,
  input  wire logic [9:0] raddr,
  output logic            rdata
);

  logic mem [flai_pkg::DEPTH];

  // Contents are not reset, so a master clear keeps the logged image.
  always_ff @(posedge sys_clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  // Read is combinational so the scan can test one location per cycle.
  assign rdata = mem[raddr];

endmodule

// ==== verilog/flai_core.sv ====
// Fault log array interface: command decode, copy, scan and fill sequencer.
`timescale 1ns/100ps

// Behaviour
// [R1] Copy-in runs from start address to last
// [R2] Copy-in busy, ready again within 100 us
// [R3] Resets terminate copy-in; copy-in beats scan
// [R4] Scan stops on logged one, ends on wrap
// [R5] Read resumes halted scan; ready after 2 us
// [R6] Commands need ready; master clear always accepted
// [R7] Control bit 4 sets correction disable
// [R8] Correction disable clears on listed events
// [R9] Bit 5 selects half one cycle later
// [R10] Control loads start address; clear keeps it
// [R11] Status shows scan in progress
// [R12] Status mirrors disable flag and half
// [R13] Copy error flag, cleared by later commands
// [R14] Status read accepted anytime, bit 1 ready
// [R15] Host writes only while ready
// [R16] Copy-out writes memory array, 100 us settle
// [R17] Block fill, overrides copy-out and single
// [R18] Single load writes one location only
// [R19] Memory array touched only at refresh
// [R20] Write bit 5 picks copy-out half
// [R21] Transfer steps with matching refresh counter
// [R22] Read returns error flag and address
// [R23] Commands sampled on the strobe cycle
module flai_core (
  input  wire logic                   sys_clk,
  input  wire logic                   sys_rst,
  input  wire flai_pkg::flai_cmd_t    cmd,
  output logic [15:0]                 resp_word,
  input  wire flai_pkg::flai_mem_in_t mem_in,
  output flai_pkg::flai_mem_out_t     mem_out,
  input  wire logic                   io_reset,
  input  wire logic                   power_fail_warning,
  input  wire logic                   power_on
);

  // Complete state of the block.
  typedef struct packed {
    flai_pkg::flai_state_t  state;
    logic [9:0]             ctr;
    logic                   half;
    logic                   dis;
    logic                   cperr;
    logic                   err_found;
    logic                   fill_bit;
    logic [10:0]            delay;
    logic [15:0]            resp;
    logic                   we;
    logic                   wbit;
    flai_pkg::flai_mem_in_t m1;
    flai_pkg::flai_mem_in_t m2;
    logic                   ref3;
    logic [2:0]             p1;
    logic [2:0]             p2;
  } flai_regs_t;

  flai_regs_t r;
  flai_regs_t next_r;
  logic       arr_we;
  logic [9:0] arr_wa;
  logic       arr_wd;
  logic       arr_rd;
  logic       rw_ok;
  logic       ref_hit;
  logic       at_last;
  logic       term;
  logic       cperr_set;
  logic       ctl_ok;
  logic       wr_ok;
  logic       mclr;

  flai_bit_array u_array (
    .sys_clk (sys_clk),
    .we      (arr_we),
    .waddr   (arr_wa),
    .wdata   (arr_wd),
    .raddr   (r.ctr),
    .rdata   (arr_rd)
  );

  // Ready only when nothing runs and the settle time has passed.
  assign rw_ok = ((r.state == flai_pkg::ST_IDLE) || (r.state == flai_pkg::ST_HALT))
                 && (r.delay == flai_pkg::DELAY_ZERO); // [R14]

  // Refresh start seen on synchronised lines, at the counter's own address.
  assign ref_hit = r.m2.refresh && !r.ref3 && (r.m2.addr == r.ctr); // [R21]
  assign at_last = (r.ctr == flai_pkg::ADDR_LAST);
  assign term    = |r.p2;
  assign mclr    = cmd.valid && (cmd.kind == flai_pkg::CMD_CONTROL) && cmd.word[flai_pkg::POS_B0];
  assign ctl_ok  = cmd.valid && (cmd.kind == flai_pkg::CMD_CONTROL) && rw_ok && !mclr; // [R6]
  assign wr_ok   = cmd.valid && (cmd.kind == flai_pkg::CMD_WRITE) && rw_ok; // [R15]

  // Next-state logic for the whole block.
  always_comb begin
    next_r    = r;
    arr_we    = 1'b0;
    arr_wa    = r.ctr;
    arr_wd    = 1'b0;
    cperr_set = 1'b0;
    // Pins from other domains pass two flip-flops before use.
    next_r.m1   = mem_in;
    next_r.m2   = r.m1;
    next_r.ref3 = r.m2.refresh;
    next_r.p1   = {io_reset, power_fail_warning, power_on};
    next_r.p2   = r.p1;
    next_r.we   = 1'b0;
    if (r.delay != flai_pkg::DELAY_ZERO) begin
      next_r.delay = r.delay - flai_pkg::DELAY_STEP;
    end
    // Sequencer progress.
    case (r.state)
      flai_pkg::ST_COPY_IN: begin
        if (ref_hit) begin
          arr_we = 1'b1; // [R1]
          arr_wd = r.m2.rd_bit;
          cperr_set = r.m2.rd_bit; // [R13]
          if (at_last) begin
            next_r.ctr   = flai_pkg::ADDR_ZERO; // [R1]
            next_r.state = flai_pkg::ST_IDLE;
            next_r.delay = flai_pkg::COPY_SETTLE; // [R2]
            next_r.dis   = 1'b0; // [R8]
          end else begin
            next_r.ctr = r.ctr + flai_pkg::ADDR_STEP; // [R21]
          end
        end
      end
      flai_pkg::ST_COPY_OUT: begin
        if (ref_hit) begin
          // The memory array is written only in its refresh slot.
          next_r.we   = 1'b1; // [R19]
          next_r.wbit = arr_rd; // [R16]
          if (at_last) begin
            next_r.ctr   = flai_pkg::ADDR_ZERO; // [R16]
            next_r.state = flai_pkg::ST_IDLE;
            next_r.delay = flai_pkg::COPY_SETTLE;
            next_r.dis   = 1'b0; // [R8]
          end else begin
            next_r.ctr = r.ctr + flai_pkg::ADDR_STEP;
          end
        end
      end
      flai_pkg::ST_FILL: begin
        // One location per cycle; the local array needs no refresh slot.
        arr_we = 1'b1; // [R17]
        arr_wd = r.fill_bit;
        if (at_last) begin
          next_r.ctr   = flai_pkg::ADDR_ZERO;
          next_r.state = flai_pkg::ST_IDLE;
          next_r.delay = flai_pkg::SCAN_SETTLE;
        end else begin
          next_r.ctr = r.ctr + flai_pkg::ADDR_STEP;
        end
      end
      flai_pkg::ST_SCAN: begin
        if (arr_rd) begin
          next_r.state     = flai_pkg::ST_HALT; // [R4]
          next_r.err_found = 1'b1;
          next_r.delay     = flai_pkg::SCAN_SETTLE; // [R5]
        end else if (at_last) begin
          next_r.ctr   = flai_pkg::ADDR_ZERO; // [R4]
          next_r.state = flai_pkg::ST_IDLE;
          next_r.delay = flai_pkg::SCAN_SETTLE; // [R5]
        end else begin
          next_r.ctr = r.ctr + flai_pkg::ADDR_STEP;
        end
      end
      flai_pkg::ST_HALT: begin
        // The read answers with the halt address, then the scan moves on.
        if (cmd.valid && (cmd.kind == flai_pkg::CMD_READ) && rw_ok) begin
          next_r.err_found = 1'b0; // [R5]
          if (at_last) begin
            next_r.ctr   = flai_pkg::ADDR_ZERO;
            next_r.state = flai_pkg::ST_IDLE;
            next_r.delay = flai_pkg::SCAN_SETTLE;
          end else begin
            next_r.ctr   = r.ctr + flai_pkg::ADDR_STEP;
            next_r.state = flai_pkg::ST_SCAN;
          end
        end
      end
      default: begin
        next_r.state = flai_pkg::ST_IDLE;
      end
    endcase
    // Command decode, only in the strobe cycle.
    if (cmd.valid) begin // [R23]
      case (cmd.kind)
        flai_pkg::CMD_STATUS: begin
          next_r.resp = '0; // [R14]
          next_r.resp[flai_pkg::POS_B1] = rw_ok;
          next_r.resp[flai_pkg::POS_B3] = (r.state == flai_pkg::ST_SCAN)
                                          || (r.state == flai_pkg::ST_HALT); // [R11]
          next_r.resp[flai_pkg::POS_B4] = r.dis; // [R12]
          next_r.resp[flai_pkg::POS_B5] = r.half; // [R12]
          next_r.resp[flai_pkg::POS_B7] = r.cperr; // [R13]
        end
        flai_pkg::CMD_READ: begin
          next_r.resp = '0; // [R22]
          next_r.resp[flai_pkg::POS_B0] = r.err_found;
          next_r.resp[flai_pkg::POS_B1] = rw_ok;
          next_r.resp[flai_pkg::POS_B3] = (r.state == flai_pkg::ST_SCAN)
                                          || (r.state == flai_pkg::ST_HALT);
          next_r.resp[flai_pkg::POS_B4] = r.dis;
          next_r.resp[flai_pkg::POS_B5] = r.half;
          next_r.resp[flai_pkg::ADDR_MSB:flai_pkg::ADDR_LSB] = r.ctr; // [R22]
        end
        flai_pkg::CMD_CONTROL: begin
          next_r.cperr = 1'b0; // [R13]
          if (mclr) begin
            // Master clear resets the card but keeps the start address and the half selection.
            next_r.state     = flai_pkg::ST_IDLE; // [R6]
            next_r.dis       = 1'b0; // [R8]
            next_r.err_found = 1'b0;
            next_r.delay     = flai_pkg::DELAY_ZERO;
            // Undo any step the sequencer took this cycle, so the address really stays.
            next_r.ctr       = r.ctr; // [R10]
          end else if (ctl_ok) begin
            next_r.ctr       = cmd.word[flai_pkg::ADDR_MSB:flai_pkg::ADDR_LSB]; // [R10]
            next_r.half      = cmd.word[flai_pkg::POS_B5]; // [R9]
            next_r.dis       = cmd.word[flai_pkg::POS_B4]; // [R7] [R8]
            next_r.err_found = 1'b0;
            // Copy-in wins when both operation bits are set.
            if (cmd.word[flai_pkg::POS_B2]) begin
              next_r.state = flai_pkg::ST_COPY_IN; // [R3]
            end else if (cmd.word[flai_pkg::POS_B3]) begin
              next_r.state = flai_pkg::ST_SCAN; // [R4]
            end else begin
              next_r.state = flai_pkg::ST_IDLE;
            end
          end
        end
        flai_pkg::CMD_WRITE: begin
          next_r.cperr = 1'b0; // [R13]
          if (wr_ok) begin
            next_r.half = cmd.word[flai_pkg::POS_B5]; // [R20]
            next_r.err_found = 1'b0;
            if (cmd.word[flai_pkg::POS_B3]) begin
              next_r.ctr      = cmd.word[flai_pkg::ADDR_MSB:flai_pkg::ADDR_LSB];
              next_r.fill_bit = cmd.word[flai_pkg::POS_B0];
              next_r.state    = flai_pkg::ST_FILL; // [R17]
            end else if (cmd.word[flai_pkg::POS_B2]) begin
              next_r.ctr   = cmd.word[flai_pkg::ADDR_MSB:flai_pkg::ADDR_LSB]; // [R20]
              next_r.state = flai_pkg::ST_COPY_OUT; // [R16]
            end else if (cmd.word[flai_pkg::POS_B4]) begin
              arr_we = 1'b1; // [R18]
              arr_wa = cmd.word[flai_pkg::ADDR_MSB:flai_pkg::ADDR_LSB];
              arr_wd = cmd.word[flai_pkg::POS_B0];
            end
          end
        end
        default: begin
          next_r.resp = r.resp;
        end
      endcase
    end
    // A logged one arriving with a clearing command is kept.
    if (cperr_set) begin
      next_r.cperr = 1'b1; // [R13]
    end
    // Power and I/O resets end any operation in flight.
    if (term) begin
      next_r.state     = flai_pkg::ST_IDLE; // [R3]
      next_r.dis       = 1'b0; // [R8]
      next_r.err_found = 1'b0;
      next_r.delay     = flai_pkg::DELAY_ZERO;
      next_r.we        = 1'b0;
    end
  end

  // State register; the array contents are left alone by reset.
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      r       <= '0;
      r.state <= flai_pkg::ST_IDLE;
    end else begin
      r <= next_r;
    end
  end

  // Outputs come straight from flip-flops.
  assign resp_word          = r.resp;
  assign mem_out.we         = r.we;
  assign mem_out.wr_bit     = r.wbit;
  assign mem_out.upper_half = r.half;
  assign mem_out.corr_disable = r.dis;

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (sys_rst);

  // Last copy-in step wraps the counter and starts the long settle.
  sequence seq_copy_last;
    (r.state == flai_pkg::ST_COPY_IN) && ref_hit && at_last && !term && !mclr;
  endsequence

  chk_copy_wrap: assert property (seq_copy_last |=> (r.ctr == flai_pkg::ADDR_ZERO) // [R1]
      && (r.delay == flai_pkg::COPY_SETTLE) && !rw_ok && !r.dis)
    else $error("copy-in did not wrap and settle");

  // Busy states never report ready.
  chk_busy_not_ready: assert property ((r.state == flai_pkg::ST_COPY_IN) // [R2]
      || (r.state == flai_pkg::ST_COPY_OUT) || (r.state == flai_pkg::ST_FILL) |-> !rw_ok)
    else $error("ready shown while busy");

  // Any termination source returns the sequencer to idle.
  chk_term_idle: assert property (term |=> (r.state == flai_pkg::ST_IDLE) && !r.dis) // [R3]
    else $error("termination did not stop the operation");

  // A logged one halts the scan at its own address.
  sequence seq_scan_hit;
    (r.state == flai_pkg::ST_SCAN) && arr_rd && !term && !cmd.valid;
  endsequence

  chk_scan_halt: assert property (seq_scan_hit |=> (r.state == flai_pkg::ST_HALT) // [R4]
      && r.err_found && (r.ctr == $past(r.ctr)))
    else $error("scan did not halt on a logged one");

  // Ready returns exactly when the short settle runs out after a halt.
  chk_halt_ready: assert property (((r.state == flai_pkg::ST_HALT) // [R5]
      && (r.delay == flai_pkg::DELAY_STEP) && !term && !cmd.valid) |=> rw_ok ##0 r.err_found)
    else $error("halt settle time wrong");

  // Reading a halted scan resumes it.
  sequence seq_halt_read;
    (r.state == flai_pkg::ST_HALT) && rw_ok && cmd.valid
      && (cmd.kind == flai_pkg::CMD_READ) && !term && !at_last;
  endsequence

  chk_read_resume: assert property (seq_halt_read |=> (r.state == flai_pkg::ST_SCAN) // [R5]
      && (r.ctr == $past(r.ctr) + flai_pkg::ADDR_STEP) && !r.err_found)
    else $error("scan did not resume after read");

  // An accepted control command sets flag, half and address as written.
  chk_control_load: assert property ((ctl_ok && !term) |=> // [R7] [R9] [R10]
      (r.dis == $past(cmd.word[flai_pkg::POS_B4]))
      && (mem_out.upper_half == $past(cmd.word[flai_pkg::POS_B5]))
      && (r.ctr == $past(cmd.word[flai_pkg::ADDR_MSB:flai_pkg::ADDR_LSB])))
    else $error("control command not applied");

  // A control command refused while busy changes nothing but the copy error flag.
  chk_busy_refuse: assert property ((cmd.valid && (cmd.kind == flai_pkg::CMD_CONTROL) // [R6]
      && !rw_ok && !mclr && !term && (r.state == flai_pkg::ST_SCAN) && !arr_rd && !at_last)
      |=> (r.state == flai_pkg::ST_SCAN) && $stable(r.half))
    else $error("busy control command took effect");

  // Copy error flag is cleared by a later control or write command unless a one lands.
  chk_cperr_clear: assert property ((cmd.valid && ((cmd.kind == flai_pkg::CMD_CONTROL) // [R13]
      || (cmd.kind == flai_pkg::CMD_WRITE)) && !cperr_set) |=> !r.cperr)
    else $error("copy error flag not cleared");

  // Memory-side writes only follow a refresh start.
  chk_mem_refresh: assert property (mem_out.we |-> $past(ref_hit) // [R19]
      && ($past(r.state) == flai_pkg::ST_COPY_OUT))
    else $error("memory array written outside refresh");

  // Single load leaves the counter alone.
  chk_single_ctr: assert property ((wr_ok && cmd.word[flai_pkg::POS_B4] // [R18]
      && !cmd.word[flai_pkg::POS_B3] && !cmd.word[flai_pkg::POS_B2] && !term)
      |=> $stable(r.ctr) && $stable(r.state))
    else $error("single load moved the counter");

  // Block fill beats copy-out in the same write.
  chk_fill_wins: assert property ((wr_ok && cmd.word[flai_pkg::POS_B3] && !term) // [R17]
      |=> (r.state == flai_pkg::ST_FILL))
    else $error("block fill did not take priority");

  // Master clear never moves the start address, even mid-scan.
  chk_clear_addr: assert property ((mclr && !term) |=> $stable(r.ctr)) // [R10]
    else $error("master clear changed the address");

endmodule

// ==== test/flai_mem_model.sv ====
// Behavioural model of the memory control card's error array and refresh counter.
`timescale 1ns/100ps
module flai_mem_model #(
  parameter int HIGH = 5,
  parameter int LOW  = 3
) (
  input  wire logic                    sys_clk,
  input  wire logic                    sys_rst,
  input  wire flai_pkg::flai_mem_out_t mem_out,
  output flai_pkg::flai_mem_in_t       mem_in,
  output logic                         stray_write
);
  // Both halves of the error array; the bench preloads them by hierarchy.
  logic       arr [2][1024];
  logic [7:0] phase;

  // Refresh slots step the counter; the address only moves while refresh is low so it stays stable in the slot.
  always @(posedge sys_clk) begin
    if (sys_rst) begin
      phase          <= 8'h00;
      mem_in.refresh <= 1'b0;
      mem_in.addr    <= 10'h000;
      mem_in.rd_bit  <= 1'b0;
      stray_write    <= 1'b0;
    end else begin
      phase          <= (int'(phase) == HIGH + LOW - 1) ? 8'h00 : phase + 8'h01;
      mem_in.refresh <= (int'(phase) < HIGH);
      if (int'(phase) == HIGH + 1) begin
        mem_in.addr <= mem_in.addr + 10'h001;
      end
      // Outside the slot the bit line is not driven, so it toggles rather than holding a stale value.
      mem_in.rd_bit <= (int'(phase) < HIGH) ? arr[mem_out.upper_half][mem_in.addr] : ~mem_in.rd_bit;
      if (mem_out.we) begin
        if (!mem_in.refresh) begin
          stray_write <= 1'b1;
        end else begin
          arr[mem_out.upper_half][mem_in.addr] <= mem_out.wr_bit;
        end
      end
    end
  end
endmodule

// ==== test/flai_core_test.sv ====
// Self-checking bench for the fault log array interface core.
`timescale 1ns/100ps
module flai_core_test;
  logic                    sys_clk;
  logic                    sys_rst;
  flai_pkg::flai_cmd_t     cmd;
  logic [15:0]             resp_word;
  flai_pkg::flai_mem_in_t  mem_in;
  flai_pkg::flai_mem_out_t mem_out;
  logic                    io_reset;
  logic                    power_fail_warning;
  logic                    power_on;
  logic                    stray;
  logic [15:0]             r;
  int                      error_cnt;
  int                      comparisons;
  int                      cyc = 0;

  flai_core dut (
    .sys_clk            (sys_clk),
    .sys_rst            (sys_rst),
    .cmd                (cmd),
    .resp_word          (resp_word),
    .mem_in             (mem_in),
    .mem_out            (mem_out),
    .io_reset           (io_reset),
    .power_fail_warning (power_fail_warning),
    .power_on           (power_on)
  );

  flai_mem_model mem (
    .sys_clk     (sys_clk),
    .sys_rst     (sys_rst),
    .mem_out     (mem_out),
    .mem_in      (mem_in),
    .stray_write (stray)
  );

  // Free-running 20 MHz clock.
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end

  // A hang ends the run long after the slowest copies should have finished.
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 80000) begin
      error_cnt++;
      stop_test();
    end
  end

  task automatic stop_test();
    if (error_cnt == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // One strobe cycle per command; the answer is read once it has settled and then stands.
  task automatic get(input flai_pkg::flai_cmd_kind_t k, input logic [15:0] w, output logic [15:0] res);
    @(posedge sys_clk);
    #5;
    cmd = '{valid: 1'b1, kind: k, word: w};
    @(posedge sys_clk);
    #5;
    cmd.valid = 1'b0;
    @(posedge sys_clk);
    #5;
    res = resp_word;
  endtask

  // Expected status word from its fields.
  function automatic logic [15:0] st(input logic rdy, input logic scn, input logic dis, input logic hlf,
                                     input logic cer);
    return {1'b0, rdy, 1'b0, scn, dis, hlf, 1'b0, cer, 8'h00};
  endfunction

  // Polls status a bounded number of times, since control and write need the ready bit.
  task automatic wait_ready();
    int n;
    n = 0;
    do begin
      get(flai_pkg::CMD_STATUS, 16'h0000, r);
      n++;
    end while (r[14] !== 1'b1 && n < 6000);
    check("ready", r & 16'h4000, 16'h4000);
  endtask

  initial begin
    cmd                = '0;
    sys_rst            = 1'b1;
    io_reset           = 1'b0;
    power_fail_warning = 1'b0;
    power_on           = 1'b0;
    error_cnt          = 0;
    comparisons        = 0;
    for (int i = 0; i < 1024; i++) begin
      mem.arr[0][i] = 1'b0;
      mem.arr[1][i] = 1'b0;
    end
    mem.arr[1][10'h3F0] = 1'b1;
    mem.arr[1][10'h3FD] = 1'b1;
    mem.arr[0][10'h3FD] = 1'b1;
    mem.arr[0][10'h3FE] = 1'b1;
    repeat (20) @(posedge sys_clk);
    #5;
    sys_rst = 1'b0;
    get(flai_pkg::CMD_STATUS, 16'h0000, r);
    check("status_reset", r, st(1, 0, 0, 0, 0));
    // Disable, upper half and a start address with no operation.
    get(flai_pkg::CMD_CONTROL, 16'h0D00, r);
    get(flai_pkg::CMD_STATUS, 16'h0000, r);
    check("status_dis_half", r, st(1, 0, 1, 1, 0));
    check("mem_out_flags", {14'h0, mem_out.corr_disable, mem_out.upper_half}, 16'h0003);
    get(flai_pkg::CMD_READ, 16'h0000, r);
    check("start_addr", r & 16'h03FF, 16'h0100);
    // Master clear with a zero address field keeps the old address and clears the disable flag.
    get(flai_pkg::CMD_CONTROL, 16'h8000, r);
    get(flai_pkg::CMD_STATUS, 16'h0000, r);
    check("status_clear", r, st(1, 0, 0, 1, 0));
    get(flai_pkg::CMD_READ, 16'h0000, r);
    check("addr_after_clear", r & 16'h03FF, 16'h0100);
    // Zero the whole local array, since it has no reset.
    get(flai_pkg::CMD_WRITE, 16'h1000, r);
    get(flai_pkg::CMD_STATUS, 16'h0000, r);
    check("fill_busy", r & 16'h4000, 16'h0000);
    wait_ready();
    get(flai_pkg::CMD_READ, 16'h0000, r);
    check("fill_counter", r & 16'h03FF, 16'h0000);
    // Copy-in with disable and a simultaneous scan, upper half, from 0x3F8.
    get(flai_pkg::CMD_CONTROL, 16'h3FF8, r);
    get(flai_pkg::CMD_STATUS, 16'h0000, r);
    check("copy_busy", r, st(0, 0, 1, 1, 0));
    wait_ready();
    check("copy_done", r, st(1, 0, 0, 1, 1));
    // Scan from 0x3F0: 0x3F0 lay before the copy start, so the first halt is 0x3FD.
    get(flai_pkg::CMD_CONTROL, 16'h17F0, r);
    get(flai_pkg::CMD_STATUS, 16'h0000, r);
    check("scan_busy", r & 16'h5D00, 16'h1400);
    wait_ready();
    check("scan_halt", r, st(1, 1, 0, 1, 0));
    get(flai_pkg::CMD_READ, 16'h0000, r);
    check("scan_addr", r, 16'hD7FD);
    wait_ready();
    check("scan_done", r, st(1, 0, 0, 1, 0));
    // Single load of a one at 0x3FF, then copy-out to the lower half from 0x3FE.
    get(flai_pkg::CMD_WRITE, 16'h8BFF, r);
    get(flai_pkg::CMD_WRITE, 16'h23FE, r);
    get(flai_pkg::CMD_STATUS, 16'h0000, r);
    check("copyout_busy", r & 16'h4000, 16'h0000);
    wait_ready();
    check("copyout_3fd", {15'h0, mem.arr[0][10'h3FD]}, 16'h0001);
    check("copyout_3fe", {15'h0, mem.arr[0][10'h3FE]}, 16'h0000);
    check("copyout_3ff", {15'h0, mem.arr[0][10'h3FF]}, 16'h0001);
    get(flai_pkg::CMD_READ, 16'h0000, r);
    check("copyout_counter", r & 16'h03FF, 16'h0000);
    // Fill ones from 0x3FC together with a single load; the fill must win.
    get(flai_pkg::CMD_WRITE, 16'h9BFC, r);
    wait_ready();
    get(flai_pkg::CMD_CONTROL, 16'h13FB, r);
    for (int i = 0; i < 4; i++) begin
      wait_ready();
      get(flai_pkg::CMD_READ, 16'h0000, r);
      check("fill_scan", r, 16'hD3FC + 16'(i));
    end
    wait_ready();
    check("fill_scan_end", r & 16'h1000, 16'h0000);
    // Each external reset source ends a copy-in and clears the disable flag.
    for (int i = 0; i < 3; i++) begin
      get(flai_pkg::CMD_CONTROL, 16'h2800, r);
      repeat (100) @(posedge sys_clk);
      #5;
      io_reset           = (i == 0);
      power_fail_warning = (i == 1);
      power_on           = (i == 2);
      repeat (4) @(posedge sys_clk);
      #5;
      io_reset           = 1'b0;
      power_fail_warning = 1'b0;
      power_on           = 1'b0;
      repeat (6) @(posedge sys_clk);
      get(flai_pkg::CMD_STATUS, 16'h0000, r);
      check("reset_abort", r & 16'h5C00, 16'h4000);
    end
    // A plain control command during a scan is refused; master clear then aborts the scan.
    get(flai_pkg::CMD_CONTROL, 16'h1000, r);
    repeat (20) @(posedge sys_clk);
    get(flai_pkg::CMD_CONTROL, 16'h0C00, r);
    get(flai_pkg::CMD_STATUS, 16'h0000, r);
    check("busy_refused", r & 16'h5C00, 16'h1000);
    get(flai_pkg::CMD_CONTROL, 16'h8000, r);
    get(flai_pkg::CMD_STATUS, 16'h0000, r);
    check("clear_abort", r & 16'h5C00, 16'h4000);
    check("stray_write", {15'h0, stray}, 16'h0000);
    stop_test();
  end
endmodule
